// ==== common/pst_pkg.sv ====
// constants and types of the pll status readback register block
package pst_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;

   // register offsets on the serial register port
   localparam logic [15:0] OFS_IRQ_ENABLE    = 16'h0079;
   localparam logic [15:0] OFS_IRQ_STICKY    = 16'h0200;
   localparam logic [15:0] OFS_REF_STATUS    = 16'h0202;
   localparam logic [15:0] OFS_LOCK_STATE    = 16'h0203;
   localparam logic [15:0] OFS_INPUT_LEVELS  = 16'h020c;
   localparam logic [15:0] OFS_IRQ_SUMMARY   = 16'h020d;
   localparam logic [15:0] OFS_BOOT_ERROR    = 16'h0210;
   localparam logic [15:0] OFS_BOOT_DONE     = 16'h0211;

   // field positions
   localparam int unsigned POS_SIGNAL_LOSS0  = 0;
   localparam int unsigned POS_SIGNAL_LOSS1  = 1;
   localparam int unsigned POS_HOLDOVER      = 4;
   localparam int unsigned POS_LOCK_LOSS     = 6;
   localparam int unsigned POS_SEL_REF       = 0;
   localparam int unsigned POS_NO_REF        = 3;
   localparam int unsigned POS_LOOP_STATE    = 0;
   localparam int unsigned POS_LOCKED        = 4;
   localparam int unsigned POS_INPUT_LEVEL   = 0;
   localparam int unsigned POS_SUMMARY       = 0;
   localparam int unsigned POS_BOOT_FAILED   = 0;
   localparam int unsigned POS_CSUM_ERROR    = 1;
   localparam int unsigned POS_BOOT_DONE     = 0;

   // writable bits of the sticky and enable registers
   localparam logic [7:0]  IRQ_BITS_MASK     = 8'h53;

   // encodings
   localparam logic [2:0]  SEL_REF_NONE      = 3'h0;
   localparam logic [2:0]  SEL_REF_INPUT0    = 3'h4;
   localparam logic [2:0]  SEL_REF_INPUT1    = 3'h5;
   localparam logic [1:0]  LOOP_CODE_FREERUN = 2'h1;
   localparam logic [1:0]  LOOP_CODE_NORMAL  = 2'h2;
   localparam logic [1:0]  LOOP_CODE_HOLD    = 2'h3;

   // reset values
   localparam logic [7:0]  RST_BYTE          = 8'h00;

   typedef enum logic [1:0] {
      PST_FREERUN,
      PST_NORMAL,
      PST_HOLDOVER
   } pst_loop_mode_t;

endpackage : pst_pkg

// ==== design/pst_status_regs.sv ====
// status register bank of the clock loop: debug view, inputs, interrupts, boot
`timescale 1ns/1ps
`default_nettype none
module pst_status_regs #(
   parameter int unsigned GPIO_N = 4
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   // register port from the serial interface
   input  wire logic [15:0]            reg_addr,
   input  wire logic                   reg_rd,
   input  wire logic                   reg_wr,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata_q,
   output logic                        reg_rvalid_q,
   // live digital loop state
   input  wire logic [1:0]             ref_valid,
   input  wire logic                   ref_active,
   input  wire logic                   ref_active_sel,
   input  wire logic                   phase_err_in_lock,
   input  wire logic                   synth_mode,
   input  wire pst_pkg::pst_loop_mode_t loop_mode,
   // general pins
   input  wire logic [GPIO_N-1:0]      general_input_level,
   input  wire logic [GPIO_N-1:0]      gpio_is_input,
   // alarm events, one cycle each
   input  wire logic                   lock_loss_evt,
   input  wire logic                   holdover_evt,
   input  wire logic [1:0]             signal_loss_evt,
   // boot sequencer events, one cycle each
   input  wire logic                   boot_checksum_error_evt,
   input  wire logic                   boot_read_failed_evt,
   input  wire logic                   boot_read_complete_evt,
   // open-drain interrupt pin
   input  wire logic                   irq_pin_low_in,
   output logic                        irq_pin_low_out,
   output logic                        irq_pin_low_oe_n
);

   logic [7:0] irq_enable_q;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;
   logic [7:0] irq_sticky_q;
   logic [2:0] boot_set;
   logic [2:0] boot_flags_q;
   logic       irq_active;
   logic       wr_sticky;
   logic       pin_seen_low_q;
   logic [2:0] selected_reference;
   logic       no_reference;
   logic       phase_locked_flag;
   logic [1:0] loop_state;
   logic [7:0] rd_mux;

   assign wr_sticky = reg_wr && (reg_addr == pst_pkg::OFS_IRQ_STICKY);

   // ---------------- debug loop view ----------------

   assign no_reference = ~|ref_valid;

   always_comb begin
      if (!ref_active) begin
         selected_reference = pst_pkg::SEL_REF_NONE;
      end else if (ref_active_sel) begin
         selected_reference = pst_pkg::SEL_REF_INPUT1;
      end else begin
         selected_reference = pst_pkg::SEL_REF_INPUT0;
      end
   end

   assign phase_locked_flag = phase_err_in_lock & ~synth_mode;

   always_comb begin
      unique case (loop_mode)
         pst_pkg::PST_FREERUN:  loop_state = pst_pkg::LOOP_CODE_FREERUN;
         pst_pkg::PST_NORMAL:   loop_state = pst_pkg::LOOP_CODE_NORMAL;
         pst_pkg::PST_HOLDOVER: loop_state = pst_pkg::LOOP_CODE_HOLD;
         default:               loop_state = pst_pkg::LOOP_CODE_FREERUN;
      endcase
   end

   // ---------------- interrupt sticky bits ----------------

   always_comb begin
      irq_set                            = '0;
      irq_set[pst_pkg::POS_SIGNAL_LOSS0] = signal_loss_evt[0];
      irq_set[pst_pkg::POS_SIGNAL_LOSS1] = signal_loss_evt[1];
      irq_set[pst_pkg::POS_HOLDOVER]     = holdover_evt;
      irq_set[pst_pkg::POS_LOCK_LOSS]    = lock_loss_evt;
   end

   assign irq_clr = wr_sticky ?
                    (reg_wdata & pst_pkg::IRQ_BITS_MASK) : 8'h00;

   pst_sticky_bits #(
      .WIDTH (8)
   ) u_irq_sticky (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .set_i   (irq_set),
      .clr_i   (irq_clr),
      .flag_q  (irq_sticky_q)
   );

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_enable_q <= pst_pkg::RST_BYTE;
      end else if (reg_wr && reg_addr == pst_pkg::OFS_IRQ_ENABLE) begin
         // reserved positions are not stored
         irq_enable_q <= reg_wdata & pst_pkg::IRQ_BITS_MASK;
      end
   end

   assign irq_active = |(irq_sticky_q & irq_enable_q);

   assign irq_pin_low_out  = 1'b0;
   assign irq_pin_low_oe_n = ~irq_active;

   // pin level kept for debug; a wired-or partner may hold it low too
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_seen_low_q <= 1'b0;
      end else begin
         pin_seen_low_q <= ~irq_pin_low_in;
      end
   end

   // ---------------- boot flags ----------------

   assign boot_set = {boot_read_complete_evt, boot_checksum_error_evt, boot_read_failed_evt};

   pst_sticky_bits #(
      .WIDTH (3)
   ) u_boot_flags (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .set_i   (boot_set),
      .clr_i   (3'h0),
      .flag_q  (boot_flags_q)
   );

   // ---------------- read path ----------------

   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         pst_pkg::OFS_IRQ_ENABLE: begin
            rd_mux = irq_enable_q;
         end
         pst_pkg::OFS_IRQ_STICKY: begin
            rd_mux = irq_sticky_q;
         end
         pst_pkg::OFS_REF_STATUS: begin
            rd_mux[pst_pkg::POS_SEL_REF +: 3] = selected_reference;
            rd_mux[pst_pkg::POS_NO_REF]       = no_reference;
         end
         pst_pkg::OFS_LOCK_STATE: begin
            rd_mux[pst_pkg::POS_LOOP_STATE +: 2] = loop_state;
            rd_mux[pst_pkg::POS_LOCKED]          = phase_locked_flag;
         end
         pst_pkg::OFS_INPUT_LEVELS: begin
            rd_mux[pst_pkg::POS_INPUT_LEVEL +: GPIO_N] = general_input_level & gpio_is_input;
         end
         pst_pkg::OFS_IRQ_SUMMARY: begin
            rd_mux[pst_pkg::POS_SUMMARY] = irq_active;
         end
         pst_pkg::OFS_BOOT_ERROR: begin
            rd_mux[pst_pkg::POS_BOOT_FAILED] = boot_flags_q[0];
            rd_mux[pst_pkg::POS_CSUM_ERROR]  = boot_flags_q[1];
         end
         pst_pkg::OFS_BOOT_DONE: begin
            rd_mux[pst_pkg::POS_BOOT_DONE] = boot_flags_q[2];
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q  <= pst_pkg::RST_BYTE;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            reg_rdata_q <= rd_mux;
         end
      end
   end

   // ---------------- assertions ----------------

   sequence rd_at(logic [15:0] a);
      reg_rd && reg_addr == a;
   endsequence

   sequence lock_alarm_enabled;
      lock_loss_evt && irq_enable_q[pst_pkg::POS_LOCK_LOSS] && !reg_wr;
   endsequence

   no_ref_read_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_REF_STATUS) |=>
         reg_rdata_q[3] == ($past(ref_valid) == 2'h0))
      else $error("no reference flag wrong");

   ref_code_read_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_REF_STATUS) ##0 ref_active |=>
         reg_rdata_q[2:1] == 2'h2 && reg_rdata_q[0] == $past(ref_active_sel))
      else $error("selected reference code wrong");

   lock_synth_gate_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_LOCK_STATE) ##0 synth_mode |=> !reg_rdata_q[4])
      else $error("lock shown in synthesizer mode");

   loop_state_code_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_LOCK_STATE) ##0 (loop_mode == pst_pkg::PST_HOLDOVER) |=>
         reg_rdata_q[1:0] == 2'h3 && reg_rdata_q[7:5] == 3'h0)
      else $error("loop state code wrong");

   input_level_read_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_INPUT_LEVELS) |=>
         reg_rdata_q[3:0] == ($past(general_input_level) & $past(gpio_is_input)))
      else $error("input level field wrong");

   irq_pin_assert_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      lock_alarm_enabled ##1 !reg_wr [*2] |-> !irq_pin_low_oe_n)
      else $error("interrupt pin not driven low");

   sticky_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      irq_sticky_q[pst_pkg::POS_LOCK_LOSS] && !irq_clr[pst_pkg::POS_LOCK_LOSS] |=>
         irq_sticky_q[pst_pkg::POS_LOCK_LOSS])
      else $error("sticky bit dropped");

   masked_quiet_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      irq_enable_q == 8'h00 |-> irq_pin_low_oe_n)
      else $error("masked bit reached the pin");

   boot_done_keep_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      boot_read_complete_evt |=> boot_flags_q[2] [*8])
      else $error("boot done flag lost");

   boot_error_keep_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $rose(boot_flags_q[1]) |-> $past(boot_checksum_error_evt) ##1 boot_flags_q[1])
      else $error("checksum error flag wrong");

   read_no_effect_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      reg_rd && !reg_wr && irq_set == 8'h00 |=> $stable(irq_sticky_q))
      else $error("read changed sticky bits");

   ref_none_read_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_REF_STATUS) ##0 !ref_active |=>
         !reg_rdata_q[2])
      else $error("reference shown while none is selected");

   summary_pin_match_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_at(pst_pkg::OFS_IRQ_SUMMARY) |=>
         reg_rdata_q[0] == !$past(irq_pin_low_oe_n))
      else $error("summary bit disagrees with interrupt pin");

   pin_readback_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !irq_pin_low_oe_n |=>
         pin_seen_low_q)
      else $error("driven interrupt pin not seen low");

   clear_set_wins_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      lock_loss_evt && irq_clr[pst_pkg::POS_LOCK_LOSS] |=>
         irq_sticky_q[pst_pkg::POS_LOCK_LOSS])
      else $error("lock loss event lost in clearing cycle");

   boot_fail_keep_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      boot_flags_q[0] |=>
         boot_flags_q[0])
      else $error("boot failure flag cleared");

endmodule // pst_status_regs
`default_nettype wire

// ==== design/pst_sticky_bits.sv ====
// a row of sticky flags: set by hardware, cleared by a clear strobe, set wins
`timescale 1ns/1ps
`default_nettype none
module pst_sticky_bits #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // set and clear
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   // held flags
   output logic      [WIDTH-1:0] flag_q
);

   logic [WIDTH-1:0] flag_d;

   // an event in the clearing cycle must not be lost
   assign flag_d = set_i | (flag_q & ~clr_i);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // pst_sticky_bits
`default_nettype wire

// ==== verif/test_pst_status_regs.sv ====
// self-checking bench of the pll status readback register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_pst_status_regs;
   logic                    sys_clk = 1'b0;
   logic                    resetn = 1'b0;
   logic [15:0]             reg_addr = 16'h0000;
   logic                    reg_rd = 1'b0;
   logic                    reg_wr = 1'b0;
   logic [7:0]              reg_wdata = 8'h00;
   logic [7:0]              reg_rdata_q;
   logic                    reg_rvalid_q;
   logic [1:0]              ref_valid = 2'h0;
   logic                    ref_active = 1'b0;
   logic                    ref_active_sel = 1'b0;
   logic                    phase_err_in_lock = 1'b0;
   logic                    synth_mode = 1'b0;
   pst_pkg::pst_loop_mode_t loop_mode = pst_pkg::PST_FREERUN;
   logic [3:0]              in_level = 4'h0;
   logic [3:0]              in_dir = 4'h0;
   logic [6:0]              ev = 7'h00;
   logic                    irq_wire;
   logic                    irq_out;
   logic                    irq_oe_n;
   int                      error_cnt = 0;
   int                      tests_run = 0;

   always #10 sys_clk = ~sys_clk;
   // pull-up on the open-drain interrupt wire
   assign irq_wire = irq_oe_n ? 1'b1 : irq_out;

   pst_status_regs #(.GPIO_N(4)) i_pst_status_regs (
      .sys_clk(sys_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .ref_valid(ref_valid), .ref_active(ref_active), .ref_active_sel(ref_active_sel),
      .phase_err_in_lock(phase_err_in_lock), .synth_mode(synth_mode), .loop_mode(loop_mode),
      .general_input_level(in_level), .gpio_is_input(in_dir),
      .lock_loss_evt(ev[6]), .holdover_evt(ev[5]), .signal_loss_evt(ev[4:3]),
      .boot_checksum_error_evt(ev[2]), .boot_read_failed_evt(ev[1]),
      .boot_read_complete_evt(ev[0]),
      .irq_pin_low_in(irq_wire), .irq_pin_low_out(irq_out), .irq_pin_low_oe_n(irq_oe_n));

   task automatic do_reset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("rvalid", 1'b1, reg_rvalid_q)
      v = reg_rdata_q;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHK($sformatf("reg %h", a), e, v)
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle event pulse; pin state is settled just after the taking edge
   task automatic pulse(input logic [6:0] v);
      @(posedge sys_clk);
      ev <= v;
      @(posedge sys_clk);
      ev <= 7'h00;
      #1;
   endtask

   task automatic t_reset();
      #1;
      `CHK("oe_n", 1'b1, irq_oe_n)
      rdchk(pst_pkg::OFS_IRQ_ENABLE, 8'h00);
      rdchk(pst_pkg::OFS_IRQ_STICKY, 8'h00);
      rdchk(pst_pkg::OFS_IRQ_SUMMARY, 8'h00);
      rdchk(pst_pkg::OFS_BOOT_ERROR, 8'h00);
      rdchk(pst_pkg::OFS_BOOT_DONE, 8'h00);
      rdchk(16'h0300, 8'h00);
   endtask

   task automatic t_loop();
      logic [1:0] codes [3];
      codes = '{pst_pkg::LOOP_CODE_FREERUN, pst_pkg::LOOP_CODE_NORMAL, pst_pkg::LOOP_CODE_HOLD};
      @(posedge sys_clk);
      ref_valid  <= 2'h0;
      ref_active <= 1'b0;
      rdchk(pst_pkg::OFS_REF_STATUS, {5'h01, pst_pkg::SEL_REF_NONE});
      @(posedge sys_clk);
      ref_valid      <= 2'h2;
      ref_active     <= 1'b1;
      ref_active_sel <= 1'b0;
      rdchk(pst_pkg::OFS_REF_STATUS, {5'h00, pst_pkg::SEL_REF_INPUT0});
      @(posedge sys_clk);
      ref_active_sel <= 1'b1;
      rdchk(pst_pkg::OFS_REF_STATUS, {5'h00, pst_pkg::SEL_REF_INPUT1});
      for (int m = 0; m < 3; m++) begin
         @(posedge sys_clk);
         loop_mode         <= pst_pkg::pst_loop_mode_t'(m);
         phase_err_in_lock <= 1'b1;
         synth_mode        <= m[0];
         rdchk(pst_pkg::OFS_LOCK_STATE, {3'h0, ~m[0], 2'h0, codes[m]});
      end
      // live view: a field change shows on the very next read
      @(posedge sys_clk);
      phase_err_in_lock <= 1'b0;
      rdchk(pst_pkg::OFS_LOCK_STATE, {6'h00, codes[2]});
   endtask

   task automatic t_gpio();
      @(posedge sys_clk);
      in_level <= 4'ha;
      in_dir   <= 4'h6;
      rdchk(pst_pkg::OFS_INPUT_LEVELS, 8'h02);
      @(posedge sys_clk);
      in_level <= 4'h5;
      in_dir   <= 4'hf;
      rdchk(pst_pkg::OFS_INPUT_LEVELS, 8'h05);
   endtask

   task automatic t_irq();
      pulse(7'h40);
      `CHK("oe_n masked", 1'b1, irq_oe_n)
      // a one-cycle alarm is only caught by its sticky bit
      rdchk(pst_pkg::OFS_IRQ_STICKY, 8'h40);
      rdchk(pst_pkg::OFS_IRQ_SUMMARY, 8'h00);
      // reserved enable positions are written as zero
      wr(pst_pkg::OFS_IRQ_ENABLE, pst_pkg::IRQ_BITS_MASK);
      rdchk(pst_pkg::OFS_IRQ_ENABLE, pst_pkg::IRQ_BITS_MASK);
      rdchk(pst_pkg::OFS_IRQ_SUMMARY, 8'h01);
      `CHK("pin low", 1'b0, irq_wire)
      rdchk(pst_pkg::OFS_IRQ_STICKY, 8'h40);
      wr(pst_pkg::OFS_IRQ_STICKY, 8'h40);
      #1;
      `CHK("oe_n cleared", 1'b1, irq_oe_n)
      // enabled lock loss pulls the pin in the cycle after the event
      pulse(7'h40);
      `CHK("oe_n on lock loss", 1'b0, irq_oe_n)
      rdchk(pst_pkg::OFS_IRQ_SUMMARY, 8'h01);
      // event and clear on one edge: the event must survive
      @(posedge sys_clk);
      ev        <= 7'h40;
      reg_addr  <= pst_pkg::OFS_IRQ_STICKY;
      reg_wdata <= 8'h40;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      ev     <= 7'h00;
      reg_wr <= 1'b0;
      #1;
      `CHK("oe_n set wins", 1'b0, irq_oe_n)
      wr(pst_pkg::OFS_IRQ_STICKY, 8'h40);
      rdchk(pst_pkg::OFS_IRQ_STICKY, 8'h00);
      pulse(7'h38);
      `CHK("oe_n on event", 1'b0, irq_oe_n)
      wr(pst_pkg::OFS_IRQ_STICKY, 8'h11);
      rdchk(pst_pkg::OFS_IRQ_STICKY, 8'h02);
      `CHK("oe_n held", 1'b0, irq_oe_n)
      wr(pst_pkg::OFS_IRQ_STICKY, 8'h02);
      rdchk(pst_pkg::OFS_IRQ_SUMMARY, 8'h00);
      `CHK("pin released", 1'b1, irq_wire)
   endtask

   task automatic t_boot();
      pulse(7'h02);
      rdchk(pst_pkg::OFS_BOOT_ERROR, 8'h01);
      pulse(7'h04);
      rdchk(pst_pkg::OFS_BOOT_ERROR, 8'h03);
      pulse(7'h01);
      wr(pst_pkg::OFS_BOOT_ERROR, 8'h00);
      wr(pst_pkg::OFS_BOOT_DONE, 8'h00);
      rdchk(pst_pkg::OFS_BOOT_ERROR, 8'h03);
      rdchk(pst_pkg::OFS_BOOT_DONE, 8'h01);
      do_reset();
      rdchk(pst_pkg::OFS_BOOT_ERROR, 8'h00);
      rdchk(pst_pkg::OFS_BOOT_DONE, 8'h00);
   endtask

   task automatic results();
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      do_reset();
      t_reset();
      t_loop();
      t_gpio();
      t_irq();
      t_boot();
      results();
   end

   // the sequence needs about 115 cycles; ten thousand means a hang
   initial begin
      repeat (10000) @(posedge sys_clk);
      error_cnt++;
      results();
   end
endmodule // test_pst_status_regs
`default_nettype wire
